// file: core/plf_pkg.sv
package plf_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 80;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
	localparam int RESP_IF_CLKS = 40;
	localparam int RESP_CYC = RESP_IF_CLKS * LINK_PERIOD_NS / SYS_PERIOD_NS;

	// ----------------------------------------------------------------
	// Packet limits and checksum
	// ----------------------------------------------------------------
	localparam int MAX_PKT_BYTES = 276;
	localparam logic [8:0] MAX_PKT_LEN = 9'(MAX_PKT_BYTES);
	localparam logic [8:0] WORD_BYTES = 9'h004;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_FIRST_MASK = 16'h03FF;

	// ----------------------------------------------------------------
	// Control symbol layout: {mark[15:12], type[11:9], param[8:0]}
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_MARK = 4'hF;
	localparam logic [2:0] CS_IDLE = 3'h0;
	localparam logic [2:0] CS_EOP = 3'h1;
	localparam logic [2:0] CS_STOMP = 3'h2;
	localparam logic [2:0] CS_RESTART = 3'h3;
	localparam logic [2:0] CS_LINKREQ = 3'h4;
	localparam logic [2:0] CS_THROTTLE = 3'h5;
	localparam logic [2:0] CS_RETRY_ACK = 3'h6;
	localparam logic [2:0] CS_NOT_ACC = 3'h7;
	localparam logic [8:0] LR_INPUT_STATUS = 9'h004;
	localparam logic [8:0] CS_NO_PARAM = 9'h000;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_PKT = 2'b10
	} plf_tx_state_type;

endpackage : plf_pkg

// file: core/plf_framer.sv
// How it works
// R01 - Link width is 8 or 16 bits; framing behaves the same for both.
// R02 - Frame line is NRZ, toggled on packet start and each control symbol.
// R03 - Any symbol holding a packet or control type field toggles the frame.
// R04 - Reference line toggles on every data tick, acting as a DDR clock.
// R05 - Frame stays for packet body words, toggles for every idle symbol.
// R06 - Frame toggles at most once per 32-bit word, on the word boundary.
// R07 - Reference line rises exactly at each 32-bit word boundary.
// R08 - Receiver flags misplaced frame toggles and corruption as recoverable errors.
// R09 - Packet ends on next packet, end, restart, link-request or stomp symbol.
// R10 - Sender may cancel a troubled packet with a stomp symbol.
// R11 - Restart-from-retry cancels a packet and releases a retry-stopped receiver.
// R12 - Link-request cancels a packet; with input-status it releases an error-stopped receiver.
// R13 - Cancelled packet is dropped quietly, then retry acknowledged unless stopped.
// R14 - Non-stopped receiver enters retry on cancel except restart or input-status.
// R15 - Pacing idles may sit inside packets; symbols carry their inverse; receiver ignores.
// R16 - Too many self-inserted pacing idles make the sender stomp the packet.
// R17 - A throttle symbol makes the sender insert exactly that many pacing idles.
// R18 - Excessive throttle requests let the sender stomp instead.
// R19 - Pacing idle starts within 40 interface clocks of a throttle symbol.
// R20 - Control symbols may be embedded anywhere inside a packet on word boundaries.
// R21 - Checksum excludes embedded control symbols and pacing idles.
// R22 - Corrupt embedded control symbol drops packet and sends not-accepted.
// R23 - Checksum is x16+x12+x5+1, preset ones, leading six bits zeroed.
// R24 - A packet may hold at most 276 bytes.
// R25 - Pacing limits are parameters; a counter tracks consecutive pacing idles.
module plf_framer #(
	parameter int W = 16,
	parameter int HALF = plf_pkg::LINK_HALF_CYC,
	parameter logic [7:0] PACE_LIMIT = 8'h20,
	parameter logic [7:0] THROT_LIMIT = 8'h40
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic pkt_valid,
	input wire logic [31:0] pkt_word,
	input wire logic pkt_first,
	input wire logic pkt_last,
	input wire logic pkt_cancel,
	output logic pkt_taken,
	output logic pkt_stomped,
	output logic lnk_tx_clk,
	output logic lnk_tx_frame,
	output logic [W-1:0] lnk_tx_data,
	input wire logic lnk_rx_clk,
	input wire logic lnk_rx_frame,
	input wire logic [W-1:0] lnk_rx_data,
	output logic [31:0] rcv_word,
	output logic rcv_valid,
	output logic rcv_first,
	output logic rcv_done,
	output logic rcv_good,
	output logic rcv_stopped_retry,
	output logic rcv_stopped_error,
	output logic link_fault
);

	localparam int HW = $clog2(HALF + 1);
	localparam logic [HW-1:0] HALF_M1 = HW'(HALF - 1);
	localparam logic [1:0] TPW_M1 = 2'(32 / W - 1); // R01
	localparam int RESP_BOUND = plf_pkg::RESP_CYC;

	typedef struct packed {
		plf_pkg::plf_tx_state_type tx_st;
		logic [HW-1:0] hcnt;
		logic [1:0] tidx;
		logic [31:0] tword;
		logic tclk;
		logic tframe;
		logic [W-1:0] tdata;
		logic taken;
		logic stomped;
		logic need_eop;
		logic [7:0] pace_cnt;
		logic [7:0] thr_left;
		logic ack_retry;
		logic ack_nacc;
		logic rc1, rc2, rcp, rcq;
		logic rf1, rf2, rflast;
		logic [W-1:0] rd1, rd2;
		logic raligned;
		logic [1:0] ridx;
		logic [31:0] rbuf;
		logic rtog;
		logic pv;
		logic [31:0] pword;
		logic ptog;
		logic rx_inpkt;
		logic [8:0] rx_len;
		logic [15:0] crc;
		logic [15:0] crc_mid;
		logic stop_retry;
		logic stop_err;
		logic [31:0] owrd;
		logic ovalid, osop, odone, ook, ofault;
	} plf_state_type;

	plf_state_type q;
	plf_state_type n;
	logic ev_bad, ev_cancel, ev_stomp_cancel, ev_restart, ev_thr, stopped_q;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] plf_ctrl(input logic [2:0] t, input logic [8:0] p);
		logic [15:0] hi;
		hi = {plf_pkg::CTRL_MARK, t, p};
		return {hi, ~hi}; // R15
	endfunction : plf_ctrl

	function automatic logic [15:0] plf_crc(input logic [15:0] c, input logic [15:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 15; i >= 0; i--)
		begin
			if (r[15] ^ d[i])
				r = (r << 1) ^ plf_pkg::CRC_POLY; // R23
			else
				r = r << 1;
		end
		return r;
	endfunction : plf_crc

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [15:0] hi;
		logic [15:0] lo;
		logic [2:0] ctype;
		logic [31:0] nw;
		logic [31:0] sh;
		logic ntog, rising, falling, tog, is_ctrl, ok_ctrl, fault, in_pkt, close;
		logic [8:0] thr_sum;
		hi = q.pword[31:16];
		lo = q.pword[15:0];
		ctype = hi[11:9];
		nw = 32'h0;
		sh = 32'h0;
		ntog = 1'b1;
		in_pkt = (q.tx_st == plf_pkg::TX_PKT);
		thr_sum = 9'h000;
		rising = 1'b0;
		falling = 1'b0;
		tog = 1'b0;
		is_ctrl = 1'b0;
		ok_ctrl = 1'b0;
		fault = 1'b0;
		close = 1'b0;
		n = q;
		n.taken = 1'b0;
		n.stomped = 1'b0;

		// Transmit: own divider makes the reference, one word per 32/W ticks
		if (q.hcnt == HALF_M1)
		begin
			n.hcnt = '0;
			n.tclk = ~q.tclk; // R04
			if (q.tidx == TPW_M1)
			begin
				n.tidx = 2'h0; // R07
				if (q.ack_nacc)
				begin
					nw = plf_ctrl(plf_pkg::CS_NOT_ACC, plf_pkg::CS_NO_PARAM); // R20
					n.ack_nacc = 1'b0;
				end
				else if (q.ack_retry)
				begin
					nw = plf_ctrl(plf_pkg::CS_RETRY_ACK, plf_pkg::CS_NO_PARAM); // R20
					n.ack_retry = 1'b0;
				end
				else if (in_pkt && (pkt_cancel || q.pace_cnt >= PACE_LIMIT ||
					q.thr_left > THROT_LIMIT))
				begin
					nw = plf_ctrl(plf_pkg::CS_STOMP, plf_pkg::CS_NO_PARAM); // R10 R16 R18
					n.tx_st = plf_pkg::TX_IDLE;
					n.need_eop = 1'b0;
					n.pace_cnt = 8'h00;
					n.thr_left = 8'h00;
					n.stomped = 1'b1;
				end
				else if (in_pkt && q.thr_left != 8'h00)
				begin
					nw = plf_ctrl(plf_pkg::CS_IDLE, plf_pkg::CS_NO_PARAM); // R17 R19
					n.thr_left = q.thr_left - 8'h01;
				end
				else if (in_pkt && q.need_eop)
				begin
					nw = plf_ctrl(plf_pkg::CS_EOP, plf_pkg::CS_NO_PARAM); // R09
					n.tx_st = plf_pkg::TX_IDLE;
					n.need_eop = 1'b0;
					n.thr_left = 8'h00;
				end
				else if (pkt_valid && (pkt_first || in_pkt))
				begin
					// Body words keep the frame; a new first word ends the old packet
					nw = pkt_word;
					ntog = pkt_first; // R03 R05
					n.taken = 1'b1;
					n.tx_st = plf_pkg::TX_PKT;
					n.need_eop = pkt_last;
					n.pace_cnt = 8'h00;
				end
				else if (in_pkt)
				begin
					nw = plf_ctrl(plf_pkg::CS_IDLE, plf_pkg::CS_NO_PARAM); // R15
					n.pace_cnt = q.pace_cnt + 8'h01; // R25
				end
				else
					nw = plf_ctrl(plf_pkg::CS_IDLE, plf_pkg::CS_NO_PARAM); // R05
				n.tword = nw;
				if (ntog)
					n.tframe = ~q.tframe; // R02 R06
			end
			else
				n.tidx = q.tidx + 2'h1;
			sh = n.tword << (int'(n.tidx) * W);
			n.tdata = sh[31 -: W];
		end
		else
			n.hcnt = q.hcnt + HW'(1);

		// Receive: two-flop sync; clock runs one stage behind data for margin
		n.rc1 = lnk_rx_clk;
		n.rc2 = q.rc1;
		n.rcp = q.rc2;
		n.rcq = q.rcp;
		n.rf1 = lnk_rx_frame;
		n.rf2 = q.rf1;
		n.rd1 = lnk_rx_data;
		n.rd2 = q.rd1;
		rising = q.rcp & ~q.rcq;
		falling = ~q.rcp & q.rcq;
		tog = (q.rf2 != q.rflast);
		n.pv = 1'b0;
		n.ovalid = 1'b0;
		n.osop = 1'b0;
		n.odone = 1'b0;
		n.ofault = 1'b0;
		fault = 1'b0;
		if (rising || falling)
		begin
			n.rflast = q.rf2;
			if (rising && (tog || (q.raligned && q.ridx == TPW_M1)))
			begin
				fault = q.raligned && tog && q.ridx != TPW_M1; // R08
				n.raligned = 1'b1;
				n.ridx = 2'h0;
				n.rtog = tog;
				n.rbuf = {q.rbuf[31-W:0], q.rd2};
			end
			else if (q.raligned)
			begin
				n.ridx = q.ridx + 2'h1;
				n.rbuf = {q.rbuf[31-W:0], q.rd2};
				if (tog)
				begin
					fault = 1'b1; // R08
					n.raligned = 1'b0;
				end
			end
			if (n.raligned && n.ridx == TPW_M1)
			begin
				n.pv = 1'b1;
				n.pword = n.rbuf;
				n.ptog = n.rtog;
			end
		end

		is_ctrl = q.pv && q.ptog && hi[15:12] == plf_pkg::CTRL_MARK;
		ok_ctrl = is_ctrl && lo == ~hi;
		ev_bad = is_ctrl && !ok_ctrl; // R22
		ev_thr = ok_ctrl && ctype == plf_pkg::CS_THROTTLE && hi[7:0] != 8'h00;
		ev_restart = ok_ctrl && ctype == plf_pkg::CS_RESTART;
		ev_cancel = q.rx_inpkt && ok_ctrl && (ctype == plf_pkg::CS_STOMP ||
			ctype == plf_pkg::CS_RESTART || ctype == plf_pkg::CS_LINKREQ); // R09
		ev_stomp_cancel = ev_cancel && ctype == plf_pkg::CS_STOMP;
		stopped_q = q.stop_retry | q.stop_err;
		close = q.rx_inpkt && q.pv && ((q.ptog && !is_ctrl) ||
			(ok_ctrl && ctype == plf_pkg::CS_EOP)); // R09

		// Releases come before new stops; a same-cycle stop lands only if stopped_q was clear
		if (ev_restart)
			n.stop_retry = 1'b0; // R11
		if (ok_ctrl && ctype == plf_pkg::CS_LINKREQ && hi[8:0] == plf_pkg::LR_INPUT_STATUS)
		begin
			n.stop_retry = 1'b0; // R12
			n.stop_err = 1'b0;
		end
		if (ev_thr)
		begin
			thr_sum = {1'b0, n.thr_left} + {1'b0, hi[7:0]}; // R17
			n.thr_left = thr_sum[8] ? 8'hFF : thr_sum[7:0];
		end
		if (close)
		begin
			n.odone = 1'b1;
			n.ook = (q.crc == 16'h0000) || (q.crc_mid == 16'h0000); // R21
			n.rx_inpkt = 1'b0;
			fault = fault | !n.ook; // R08
		end
		if (q.pv && !q.ptog && q.rx_inpkt)
		begin
			if (q.rx_len + plf_pkg::WORD_BYTES > plf_pkg::MAX_PKT_LEN)
				fault = 1'b1; // R24
			else
			begin
				n.rx_len = q.rx_len + plf_pkg::WORD_BYTES;
				n.crc_mid = plf_crc(q.crc, hi); // R21
				n.crc = plf_crc(n.crc_mid, lo);
				n.owrd = q.pword;
				n.ovalid = 1'b1;
			end
		end
		if (ev_cancel)
		begin
			n.rx_inpkt = 1'b0; // R13
			n.odone = 1'b1;
			n.ook = 1'b0;
			if (!stopped_q)
			begin
				n.ack_retry = 1'b1; // R13
				if (ctype == plf_pkg::CS_STOMP || (ctype == plf_pkg::CS_LINKREQ &&
					hi[8:0] != plf_pkg::LR_INPUT_STATUS))
					n.stop_retry = 1'b1; // R14
			end
		end
		if (fault || ev_bad)
		begin
			n.ofault = 1'b1;
			if (n.rx_inpkt)
			begin
				n.odone = 1'b1;
				n.ook = 1'b0;
			end
			n.rx_inpkt = 1'b0; // R22
			if (!stopped_q)
			begin
				n.ack_nacc = 1'b1; // R22
				n.stop_err = 1'b1; // R08
			end
		end
		else if (q.pv && q.ptog && !is_ctrl && !(n.stop_retry || n.stop_err))
		begin
			n.rx_inpkt = 1'b1;
			n.rx_len = plf_pkg::WORD_BYTES;
			n.crc_mid = plf_crc(plf_pkg::CRC_INIT, hi & plf_pkg::CRC_FIRST_MASK); // R23
			n.crc = plf_crc(n.crc_mid, lo);
			n.owrd = q.pword;
			n.ovalid = 1'b1;
			n.osop = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			q <= '0;
			q.tx_st <= plf_pkg::TX_IDLE;
			q.tidx <= TPW_M1;
			q.crc <= plf_pkg::CRC_INIT;
		end
		else if (ce)
			q <= n;
	end

	assign pkt_taken = q.taken;
	assign pkt_stomped = q.stomped;
	assign lnk_tx_clk = q.tclk;
	assign lnk_tx_frame = q.tframe;
	assign lnk_tx_data = q.tdata;
	assign rcv_word = q.owrd;
	assign rcv_valid = q.ovalid;
	assign rcv_first = q.osop;
	assign rcv_done = q.odone;
	assign rcv_good = q.ook;
	assign rcv_stopped_retry = q.stop_retry;
	assign rcv_stopped_error = q.stop_err;
	assign link_fault = q.ofault;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking plf_cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_frame_on_rise: assert property ($changed(lnk_tx_frame) |-> $rose(lnk_tx_clk)) // R02 R07
		else $error("frame moved without reference rising");
	a_frame_word_edge: assert property ($changed(lnk_tx_frame) |-> q.tidx == 2'h0) // R06
		else $error("frame moved off a word boundary");
	a_ddr_tick_clock: assert property ($changed(lnk_tx_data) |-> $changed(lnk_tx_clk)) // R04
		else $error("data moved without a reference edge");
	a_ctrl_inverse_half: assert property ($changed(lnk_tx_frame) &&
		q.tword[31:28] == plf_pkg::CTRL_MARK |-> q.tword[15:0] == ~q.tword[31:16]) // R15
		else $error("control symbol sent without its inverse");
	a_pace_count_bound: assert property (q.pace_cnt <= PACE_LIMIT) // R16
		else $error("pacing idles ran past the limit");
	a_throttle_idle_resp: assert property (ce && ev_thr && q.tx_st == plf_pkg::TX_PKT
		|-> ##[1:RESP_BOUND] $changed(lnk_tx_frame)) // R19
		else $error("no pacing idle after throttle");
	a_cancel_retry_ack: assert property (ce && ev_stomp_cancel && !stopped_q
		|=> q.ack_retry && q.stop_retry && !q.rx_inpkt) // R14
		else $error("stomp did not start retry");
	a_restart_release: assert property (ce && ev_restart |=> !q.stop_retry) // R11
		else $error("restart did not release receiver");
	a_corrupt_not_acc: assert property (ce && ev_bad && !stopped_q
		|=> q.ack_nacc && q.stop_err && !q.rx_inpkt) // R22
		else $error("corrupt control symbol not refused");
	a_packet_len_cap: assert property (q.rx_len <= plf_pkg::MAX_PKT_LEN) // R24
		else $error("packet length above maximum");

endmodule : plf_framer

// file: dv/plf_far_end.sv
module plf_far_end (
	input wire logic lnk_tx_clk,
	input wire logic lnk_tx_frame,
	input wire logic [15:0] lnk_tx_data,
	output logic lnk_rx_clk,
	output logic lnk_rx_frame,
	output logic [15:0] lnk_rx_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [32:0] send_q[$];
	logic [32:0] seen_q[$];
	logic [32:0] u;
	logic [32:0] e;
	logic [15:0] hi;
	logic fr;
	logic pf = 1'b0;
	time thr_t = 0;
	time pace_t = 0;
	time tr;
	int bad = 0;

	// ----------------
	// Transmit
	// ----------------
	// Idles fill every gap, so the reference keeps running between packets
	initial
	begin
		lnk_rx_clk = 1'b0;
		lnk_rx_frame = 1'b0;
		lnk_rx_data = 16'h0000;
		#3;
		forever
		begin
			u = send_q.size() != 0 ? send_q.pop_front() : {1'b1, 32'hF000_0FFF};
			lnk_rx_frame = lnk_rx_frame ^ u[32];
			lnk_rx_data = u[31:16];
			lnk_rx_clk = 1'b1;
			#40;
			lnk_rx_data = u[15:0];
			lnk_rx_clk = 1'b0;
			if (u[32] && u[31:25] == 7'h7D)
				thr_t = $time;
			#40;
		end
	end

	// ----------------
	// Receive
	// ----------------
	// Sampled just after each edge, as the lines move with the edges
	always @(posedge lnk_tx_clk)
	begin
		tr = $time;
		#1;
		hi = lnk_tx_data;
		fr = lnk_tx_frame;
		@(negedge lnk_tx_clk);
		#1;
		if (lnk_tx_frame !== fr)
			bad++;
		e = {fr ^ pf, hi, lnk_tx_data};
		pf = fr;
		if (e[32] && hi[15:12] == 4'hF)
		begin
			if (e[15:0] !== ~hi)
				bad++;
			if (hi[11:9] == 3'h0 && thr_t != 0 && pace_t < thr_t)
				pace_t = tr;
		end
		seen_q.push_back(e);
	end
endmodule : plf_far_end

// file: dv/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0, reset_n = 1'b0, pkt_valid = 1'b0, pkt_first = 1'b0;
	logic pkt_last = 1'b0, pkt_cancel = 1'b0, stomped = 1'b0, last_good;
	logic [31:0] pkt_word = 32'h0000_0000;
	logic pkt_taken, pkt_stomped, lnk_tx_clk, lnk_tx_frame, lnk_rx_clk, lnk_rx_frame;
	logic [15:0] lnk_tx_data, lnk_rx_data;
	logic [31:0] rcv_word;
	logic rcv_valid, rcv_done, rcv_good, rcv_stopped_retry, rcv_stopped_error;
	logic rcv_first, link_fault;
	logic ce = 1'b1;
	logic [17:0] hold;
	int error_cnt = 0, cmp_count = 0, dones = 0, firsts = 0, faults = 0;
	logic [31:0] got_q[$], exp_q[$];

	always #5 clk_sys = ~clk_sys;

	plf_framer #(.W(16), .PACE_LIMIT(8'h04), .THROT_LIMIT(8'h04)) u_dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .pkt_valid(pkt_valid),
		.pkt_word(pkt_word), .pkt_first(pkt_first), .pkt_last(pkt_last),
		.pkt_cancel(pkt_cancel), .pkt_taken(pkt_taken), .pkt_stomped(pkt_stomped),
		.lnk_tx_clk(lnk_tx_clk), .lnk_tx_frame(lnk_tx_frame), .lnk_tx_data(lnk_tx_data),
		.lnk_rx_clk(lnk_rx_clk), .lnk_rx_frame(lnk_rx_frame), .lnk_rx_data(lnk_rx_data),
		.rcv_word(rcv_word), .rcv_valid(rcv_valid), .rcv_first(rcv_first),
		.rcv_done(rcv_done), .rcv_good(rcv_good), .rcv_stopped_retry(rcv_stopped_retry),
		.rcv_stopped_error(rcv_stopped_error), .link_fault(link_fault));

	plf_far_end u_far (.lnk_tx_clk(lnk_tx_clk), .lnk_tx_frame(lnk_tx_frame),
		.lnk_tx_data(lnk_tx_data), .lnk_rx_clk(lnk_rx_clk), .lnk_rx_frame(lnk_rx_frame),
		.lnk_rx_data(lnk_rx_data));

	always @(posedge clk_sys)
	begin
		if (rcv_valid === 1'b1)
			got_q.push_back(rcv_word);
		if (rcv_done === 1'b1)
			dones++;
		if (rcv_first === 1'b1)
			firsts++;
		if (link_fault === 1'b1)
			faults++;
		if (rcv_done === 1'b1)
			last_good = rcv_good;
		if (pkt_stomped === 1'b1)
			stomped = 1'b1;
	end

	// ----------------
	// Helpers
	// ----------------
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] cs(input logic [2:0] t, input logic [8:0] p);
		return {4'hF, t, p, ~{4'hF, t, p}};
	endfunction : cs

	// Serial form, one bit at a time, independent of the parallel hardware
	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] d);
		for (int i = 15; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? plf_pkg::CRC_POLY : 16'h0000);
		return c;
	endfunction : crc16

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	// ----------------
	// Transmit side
	// ----------------
	// Mode 0 ends normally, 1 cancels before word k, 2 stalls before word k
	task automatic tx_pkt(input int n, input int mode, input int k);
		logic [31:0] w;
		int b;
		@(negedge clk_sys);
		for (int i = 0; i < n; i++)
		begin
			w = $urandom();
			if (i == 0)
				w[31:28] = 4'h1;
			if (mode != 0 && i == k)
				break;
			pkt_valid = 1'b1;
			pkt_word = w;
			pkt_first = i == 0;
			pkt_last = i == n - 1;
			b = 0;
			do @(negedge clk_sys); while (pkt_taken !== 1'b1 && pkt_stomped !== 1'b1 && ++b < 900);
			if (pkt_stomped === 1'b1)
				break;
			exp_q.push_back(w);
		end
		pkt_valid = 1'b0;
		pkt_cancel = mode == 1;
		b = 0;
		while (mode != 0 && pkt_stomped !== 1'b1 && ++b < 3000)
			@(negedge clk_sys);
		pkt_cancel = 1'b0;
	endtask : tx_pkt

	task automatic tx_run(input int n, input int mode, input int k, input logic [8:0] thr,
		input int idl, input logic [2:0] term);
		logic [32:0] e;
		int j, ni;
		u_far.seen_q.delete();
		exp_q.delete();
		stomped = 1'b0;
		j = 0;
		ni = 0;
		fork
			tx_pkt(n, mode, k);
			if (thr != 9'h000)
			begin
				@(posedge pkt_taken);
				u_far.send_q.push_back({1'b1, cs(plf_pkg::CS_THROTTLE, thr)});
			end
		join
		repeat (400) @(negedge clk_sys);
		while (u_far.seen_q.size() > 1 && u_far.seen_q[0][31:0] !== exp_q[0])
			void'(u_far.seen_q.pop_front());
		while (u_far.seen_q.size() != 0)
		begin
			e = u_far.seen_q.pop_front();
			if (e[32] && e[31:25] == 7'h78)
				ni++;
			else if (j < exp_q.size())
			begin
				check("tx word", e, {j == 0, exp_q[j]});
				j++;
			end
			else
			begin
				check("tx end", {e[32], e[31:25]}, {1'b1, 4'hF, term});
				break;
			end
		end
		if (idl >= 0)
			check("pacing idles", ni, idl);
		if (idl > 0)
			check("pace delay", u_far.pace_t - u_far.thr_t <=
				plf_pkg::RESP_IF_CLKS * plf_pkg::LINK_PERIOD_NS, 1);
		check("stomp pulse", stomped, term == plf_pkg::CS_STOMP);
		$display("tx test done: %0d words", n);
	endtask : tx_run

	// ----------------
	// Receive side
	// ----------------
	task automatic rx_case(input int n, input int reps, input logic [2:0] term,
		input logic [8:0] p, input bit bad, input logic eg, input logic sr,
		input logic se, input logic [2:0] er);
		logic [31:0] w, v[$];
		logic [15:0] c;
		logic [2:0] r;
		int d0, b, f0, fl0;
		got_q.delete();
		u_far.seen_q.delete();
		d0 = dones;
		f0 = firsts;
		fl0 = faults;
		r = 3'h0;
		b = 0;
		for (int q = 0; q < reps; q++)
		begin
			c = plf_pkg::CRC_INIT;
			for (int i = 0; i < n; i++)
			begin
				w = $urandom();
				if (i == 0)
					w[31:28] = 4'h2;
				c = crc16(c, i == 0 ? w[31:16] & plf_pkg::CRC_FIRST_MASK : w[31:16]);
				if (i == n - 1)
					w[15:0] = c;
				else
					c = crc16(c, w[15:0]);
				v.push_back(w);
				u_far.send_q.push_back({i == 0, w});
				if (i == 1)
					u_far.send_q.push_back({1'b1, bad ? 32'hF000_F000 : cs(3'h0, 9'h000)});
			end
		end
		u_far.send_q.push_back({1'b1, cs(term, p)});
		while (u_far.send_q.size() != 0 && ++b < 9000)
			@(negedge clk_sys);
		repeat (150) @(negedge clk_sys);
		foreach (u_far.seen_q[i])
			if (u_far.seen_q[i][32] && u_far.seen_q[i][31:26] == 6'h3F)
				r = u_far.seen_q[i][27:25];
		if (eg)
		begin
			check("rx done", dones - d0, reps);
			check("rx good", last_good, 1'b1);
			check("rx count", got_q.size(), v.size());
			check("rx first", firsts - f0, reps);
			foreach (v[i])
				check("rx word", got_q[i], v[i]);
		end
		check("stop retry", rcv_stopped_retry, sr);
		check("stop error", rcv_stopped_error, se);
		check("response", r, er);
		check("fault seen", faults != fl0, se);
		$display("rx test done: %0d words", n);
	endtask : rx_case

	initial
	begin
		#500000;
		error_cnt++;
		$display("watchdog expired");
		give_verdict();
	end

	initial
	begin
		void'($urandom(47751));
		repeat (4) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (50) @(negedge clk_sys);
		ce = 1'b0;
		hold = {lnk_tx_clk, lnk_tx_frame, lnk_tx_data};
		repeat (3) @(negedge clk_sys);
		check("ce freeze", {lnk_tx_clk, lnk_tx_frame, lnk_tx_data}, hold);
		ce = 1'b1;
		repeat (50) @(negedge clk_sys);
		u_far.seen_q.delete();
		repeat (200) @(negedge clk_sys);
		foreach (u_far.seen_q[i])
			check("idle unit", u_far.seen_q[i], {1'b1, cs(3'h0, 9'h000)});
		$display("idle test done");
		tx_run(5, 0, 0, 9'h000, 0, plf_pkg::CS_EOP);
		tx_run(6, 1, 3, 9'h000, -1, plf_pkg::CS_STOMP);
		tx_run(6, 2, 2, 9'h000, -1, plf_pkg::CS_STOMP);
		tx_run(10, 0, 0, 9'h003, 3, plf_pkg::CS_EOP);
		tx_run(10, 0, 0, 9'h005, -1, plf_pkg::CS_STOMP);
		rx_case(4, 1, plf_pkg::CS_EOP, 9'h000, 0, 1, 0, 0, 3'h0);
		rx_case(3, 2, plf_pkg::CS_EOP, 9'h000, 0, 1, 0, 0, 3'h0);
		rx_case(3, 1, plf_pkg::CS_STOMP, 9'h000, 0, 0, 1, 0, 3'h6);
		rx_case(2, 1, plf_pkg::CS_STOMP, 9'h000, 0, 0, 1, 0, 3'h0);
		rx_case(0, 0, plf_pkg::CS_RESTART, 9'h000, 0, 0, 0, 0, 3'h0);
		rx_case(3, 1, plf_pkg::CS_LINKREQ, 9'h000, 0, 0, 1, 0, 3'h6);
		rx_case(0, 0, plf_pkg::CS_LINKREQ, plf_pkg::LR_INPUT_STATUS, 0, 0, 0, 0, 3'h0);
		rx_case(2, 1, plf_pkg::CS_RESTART, 9'h000, 0, 0, 0, 0, 3'h6);
		rx_case(3, 1, plf_pkg::CS_EOP, 9'h000, 1, 0, 0, 1, 3'h7);
		rx_case(0, 0, plf_pkg::CS_LINKREQ, plf_pkg::LR_INPUT_STATUS, 0, 0, 0, 0, 3'h0);
		rx_case(70, 1, plf_pkg::CS_EOP, 9'h000, 0, 0, 0, 1, 3'h7);
		rx_case(0, 0, plf_pkg::CS_LINKREQ, plf_pkg::LR_INPUT_STATUS, 0, 0, 0, 0, 3'h0);
		rx_case(5, 1, plf_pkg::CS_EOP, 9'h000, 0, 1, 0, 0, 3'h0);
		check("far end framing", u_far.bad, 0);
		give_verdict();
	end
endmodule : tb_top
